// ==== hw/dlt_timer.sv ====
// Discrete logic timer: combines four discrete inputs and shapes the result
// with a selectable timer function, once per execution period.
// Assumes all inputs are synchronous to clk_sys and a plain register port.
//
// Functional notes
// R1: Clearing quiescence zeroes elapsed and remaining.
// R2: Hold-last quiescence keeps final times until reactivation.
// R3: Reset edge zeroes elapsed, reinitialises output, remaining.
// R4: Count combined rising edges; reset edge clears count.
// R5: Measure: output follows input, times true interval.
// R6: Accumulate: totals true time until reset edge.
// R7: Compare: output true once elapsed reaches setpoint.
// R8: Compare: input false forces output false.
// R9: Delay: rising passes after setpoint, falling immediately.
// R10: Extend: falling held for setpoint, rising immediately.
// R11: Debounce: new level must hold full setpoint.
// R12: Pulse: fixed pulse, rising edges during it ignored.
// R13: Retrigger pulse: rising edge restarts, output stays true.
// R14: Operator reset clears itself next execution.
// R15: Inversion mask flips inputs and the output; the output is flipped in automatic mode only, not manual.
// R16: First execution sets output and times per table.
// R17: Setpoint-dependent initial values follow quiescence option.
// R18: Invalid units or quiescence option flags config error.
// R19: Out of service mode sets fault flag.
// R20: Automatic mode copies raw output to output.
// R21: Combine four inputs with selected combine function.
// R22: Timer advances one execution per execution period.
`timescale 1ns/1ns
module dlt_timer
    import dlt_pkg::*;
#(
    parameter int TW = 32,
    parameter int EXEC_CYC = EXEC_CYCLES
) (
    // Clock and reset.
    input wire logic clk_sys,
    input wire logic sys_rst,
    // Register port.
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    // Discrete inputs and timer reset.
    input wire logic [3:0] discrete_in,
    input wire logic timer_reset_in,
    input wire logic timer_reset_connected,
    // Discrete output.
    output logic discrete_out
);

    // Parameters that the logic cannot serve are refused.
    generate
        if (TW < 8 || TW > 32 || EXEC_CYC < 1) begin : g_bad_param
            $error("dlt_timer: unsupported parameter value");
        end
    endgenerate

    localparam int DW = $clog2(EXEC_CYC + 1);

    logic [31:0] ctrl_r;
    logic [TW-1:0] setpt_r;
    logic op_rst_r;
    logic man_val_r;
    logic [DW-1:0] div_r;
    logic exec_en;
    logic init_r;
    logic cin_prev_r;
    logic rst_prev_r;
    logic raw_r;
    logic raw_nxt;
    logic [TW-1:0] exp_r;
    logic [TW-1:0] exp_nxt;
    logic [TW-1:0] rem_r;
    logic [TW-1:0] rem_nxt;
    logic [31:0] nstart_r;
    logic discrete_out_r;
    logic [31:0] rdata_r;
    logic [2:0] tt;
    logic [7:0] comb_sel;
    logic [1:0] quies_option;
    logic [1:0] op_mode;
    logic [3:0] time_units;
    logic [4:0] inversion_mask;
    logic [3:0] din_eff;
    logic [2:0] ones_cnt;
    logic combined_input;
    logic cin_rise;
    logic cin_edge;
    logic rst_lvl;
    logic rst_edge;
    logic run_en;
    logic cfg_err;
    logic oos_flag;
    logic [TW-1:0] spv;
    logic [TW-1:0] t_run;
    logic [TW-1:0] t_cur;
    logic pend;

    // Control fields.
    assign tt = ctrl_r[CTRL_TYPE_LSB +: 3];
    assign comb_sel = ctrl_r[CTRL_COMB_LSB +: 8];
    assign quies_option = ctrl_r[CTRL_QUIES_LSB +: 2];
    assign op_mode = ctrl_r[CTRL_OPMODE_LSB +: 2];
    assign time_units = ctrl_r[CTRL_UNITS_LSB +: 4];
    assign inversion_mask = ctrl_r[CTRL_INV_LSB +: 5];

    // Fault flags.
    assign cfg_err = (quies_option > QUIES_LAST) || (time_units > UNITS_MAX); // R18
    assign oos_flag = (op_mode == OPM_OOS); // R19

    // Execution period divider: one enable pulse per execution.
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            div_r <= '0;
        end else if (div_r == DW'(EXEC_CYC - 1)) begin
            div_r <= '0;
        end else begin
            div_r <= div_r + 1'b1;
        end
    end
    assign exec_en = (div_r == DW'(EXEC_CYC - 1));
    assign run_en = exec_en && !oos_flag;

    // Input inversion and combine function.
    assign din_eff = discrete_in ^ inversion_mask[3:0]; // R15
    always_comb begin
        ones_cnt = 3'h0;
        for (int i = 0; i < 4; i++) begin
            ones_cnt = ones_cnt + {2'h0, din_eff[i]};
        end
        unique case (comb_sel) // R21
            CMB_AND: combined_input = (ones_cnt == 3'h4);
            CMB_OR: combined_input = (ones_cnt != 3'h0);
            CMB_ANY2: combined_input = (ones_cnt >= 3'h2);
            CMB_ANY3: combined_input = (ones_cnt >= 3'h3);
            CMB_EXACT1: combined_input = (ones_cnt == 3'h1);
            CMB_EXACT2: combined_input = (ones_cnt == 3'h2);
            CMB_EXACT3: combined_input = (ones_cnt == 3'h3);
            CMB_EVEN: combined_input = !ones_cnt[0];
            CMB_ODD: combined_input = ones_cnt[0];
            default: combined_input = 1'b0;
        endcase
    end
    assign cin_rise = combined_input && !cin_prev_r;
    assign cin_edge = combined_input != cin_prev_r;

    // Timer reset source: pin when connected, operator bit otherwise.
    assign rst_lvl = timer_reset_connected ? timer_reset_in : op_rst_r;
    assign rst_edge = rst_lvl && !rst_prev_r;

    // Setpoint-dependent initial value and running time.
    assign spv = (quies_option == QUIES_LAST) ? setpt_r : '0; // R17
    assign t_run = exp_r + 1'b1; // R22
    assign pend = (combined_input != raw_r) &&
                  ((tt == TT_DEBOUNCE) || (combined_input == (tt != TT_EXTEND)));
    assign t_cur = cin_edge ? '0 : t_run;

    // Next raw output and times for one execution.
    always_comb begin
        raw_nxt = raw_r;
        exp_nxt = exp_r;
        rem_nxt = rem_r;
        if (init_r || rst_edge) begin
            exp_nxt = '0; // R3
            rem_nxt = '0;
            raw_nxt = 1'b0;
            unique case (tt) // R16
                TT_MEASURE, TT_ACCUMULATE_MODE: raw_nxt = combined_input;
                TT_COMPARE, TT_DELAY: begin
                    if (combined_input) begin
                        rem_nxt = spv;
                    end else begin
                        exp_nxt = spv;
                    end
                end
                TT_EXTEND: begin
                    raw_nxt = 1'b1;
                    if (combined_input) begin
                        exp_nxt = spv;
                    end else begin
                        rem_nxt = spv;
                    end
                end
                TT_DEBOUNCE: begin
                    raw_nxt = combined_input;
                    exp_nxt = spv;
                end
                TT_PULSE, TT_RTPULSE: begin
                    if (combined_input) begin
                        exp_nxt = spv;
                    end
                end
            endcase
            if (rst_edge) begin
                exp_nxt = '0; // R3
            end
        end else begin
            unique case (tt)
                TT_MEASURE: begin
                    raw_nxt = combined_input; // R5
                    rem_nxt = '0;
                    if (combined_input) begin
                        exp_nxt = cin_rise ? '0 : t_run;
                    end else if (quies_option == QUIES_CLEAR) begin // R2
                        exp_nxt = '0; // R1
                    end
                end
                TT_ACCUMULATE_MODE: begin
                    raw_nxt = combined_input; // R6
                    rem_nxt = '0;
                    if (combined_input) begin
                        exp_nxt = t_run;
                    end
                end
                TT_COMPARE, TT_DELAY, TT_EXTEND, TT_DEBOUNCE: begin
                    if (pend) begin
                        exp_nxt = t_cur; // R9 R10 R11
                        if (t_cur >= setpt_r) begin
                            raw_nxt = combined_input; // R7
                            rem_nxt = '0;
                        end else begin
                            rem_nxt = setpt_r - t_cur; // R7
                        end
                    end else if (combined_input && (tt == TT_COMPARE || tt == TT_DELAY)) begin
                        exp_nxt = t_run; // R7
                        rem_nxt = '0;
                    end else begin
                        raw_nxt = combined_input; // R8 R9 R10
                        if (quies_option == QUIES_CLEAR) begin
                            exp_nxt = '0; // R1
                            rem_nxt = '0;
                        end
                    end
                end
                TT_PULSE, TT_RTPULSE: begin
                    if (cin_rise && (!raw_r || tt == TT_RTPULSE)) begin
                        exp_nxt = '0; // R12 R13
                        raw_nxt = (setpt_r != '0);
                        rem_nxt = setpt_r;
                    end else if (raw_r) begin
                        exp_nxt = t_run; // R12
                        if (t_run >= setpt_r) begin
                            raw_nxt = 1'b0;
                            rem_nxt = '0;
                        end else begin
                            rem_nxt = setpt_r - t_run;
                        end
                    end else if (quies_option == QUIES_CLEAR) begin
                        exp_nxt = '0; // R1
                        rem_nxt = '0;
                    end
                end
            endcase
        end
    end

    // Timer state, updated once per execution while in service.
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            init_r <= 1'b1;
            raw_r <= 1'b0;
            exp_r <= '0;
            rem_r <= '0;
            cin_prev_r <= 1'b0;
            rst_prev_r <= 1'b0;
        end else if (run_en) begin
            init_r <= 1'b0;
            raw_r <= raw_nxt;
            exp_r <= exp_nxt;
            rem_r <= rem_nxt;
            cin_prev_r <= combined_input;
            rst_prev_r <= rst_lvl;
        end
    end

    // Start edge counter.
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            nstart_r <= '0;
        end else if (run_en) begin
            if (rst_edge) begin
                nstart_r <= '0; // R4
            end else if (cin_rise && !init_r) begin
                nstart_r <= nstart_r + 1'b1; // R4
            end
        end
    end

    // Final output: raw copy in automatic, operator value in manual.
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            discrete_out_r <= 1'b0;
        end else if (run_en && op_mode == OPM_AUTO) begin
            discrete_out_r <= raw_nxt ^ inversion_mask[4]; // R20 R15
        end else if (run_en && op_mode == OPM_MAN) begin
            discrete_out_r <= man_val_r;
        end
    end
    assign discrete_out = discrete_out_r;

    // Software-written configuration.
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            ctrl_r <= CTRL_RST;
            setpt_r <= SETPT_RST[TW-1:0];
            man_val_r <= 1'b0;
        end else if (reg_wr) begin
            if (reg_addr == REG_CTRL) begin
                ctrl_r <= reg_wdata;
            end
            if (reg_addr == REG_SETPT) begin
                setpt_r <= reg_wdata[TW-1:0];
            end
            if (reg_addr == REG_OPER) begin
                man_val_r <= reg_wdata[OPER_MANVAL_BIT];
            end
        end
    end

    // Operator reset: self-clears on the next execution; a write wins.
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            op_rst_r <= 1'b0;
        end else if (reg_wr && reg_addr == REG_OPER && reg_wdata[OPER_RESET_BIT]) begin
            op_rst_r <= 1'b1;
        end else if (run_en) begin
            op_rst_r <= 1'b0; // R14
        end
    end

    // Read data, valid the cycle after the read strobe only.
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            rdata_r <= '0;
        end else if (reg_rd) begin
            unique case (reg_addr)
                REG_CTRL: rdata_r <= ctrl_r;
                REG_SETPT: rdata_r <= 32'(setpt_r);
                REG_OPER: rdata_r <= {30'h0, man_val_r, op_rst_r};
                REG_STAT: rdata_r <= {26'h0, oos_flag, cfg_err, init_r, combined_input,
                                      raw_r, discrete_out_r};
                REG_ELAPSED: rdata_r <= 32'(exp_r);
                REG_REMAIN: rdata_r <= 32'(rem_r);
                REG_NSTART: rdata_r <= nstart_r;
                default: rdata_r <= '0;
            endcase
        end else begin
            rdata_r <= '0;
        end
    end
    assign reg_rdata = rdata_r;

    // Checks on the timer behaviour.
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (sys_rst);
    sequence s_norm_exec;
        run_en && !init_r && !rst_edge;
    endsequence

    reset_edge_a: assert property (run_en && rst_edge |=> exp_r == '0 && nstart_r == '0) // R3
        else $error("reset edge did not clear elapsed or count");
    edge_count_a: assert property (s_norm_exec and cin_rise |=> // R4
        nstart_r == $past(nstart_r) + 1)
        else $error("start edge not counted");
    measure_follow_a: assert property (s_norm_exec and tt == TT_MEASURE |=> // R5
        raw_r == $past(combined_input) && rem_r == '0)
        else $error("measure output does not follow input");
    accumulate_mode_hold_a: assert property (s_norm_exec and tt == TT_ACCUMULATE_MODE && !combined_input |=> // R6
        exp_r == $past(exp_r) && rem_r == '0)
        else $error("accumulated time changed while input false");
    quies_clear_a: assert property (s_norm_exec and tt == TT_COMPARE && !combined_input && // R1
        quies_option == QUIES_CLEAR |=> exp_r == '0 && rem_r == '0)
        else $error("times not cleared in quiescence");
    quies_hold_a: assert property (s_norm_exec and !combined_input && // R2
        (tt == TT_COMPARE || tt == TT_MEASURE) && quies_option == QUIES_LAST |=>
        exp_r == $past(exp_r) && rem_r == $past(rem_r))
        else $error("times not held in quiescence");
    compare_false_a: assert property (s_norm_exec and tt == TT_COMPARE && // R8
        !combined_input |=> !raw_r)
        else $error("compare output true with input false");
    delay_wait_a: assert property (s_norm_exec and tt == TT_DELAY && combined_input && // R9
        !raw_r && t_cur < setpt_r |=> !raw_r && rem_r == $past(setpt_r - t_cur))
        else $error("delay passed edge early");
    pulse_ignore_a: assert property (s_norm_exec and tt == TT_PULSE && raw_r && cin_rise && // R12
        t_run < setpt_r |=> raw_r && exp_r == $past(t_run))
        else $error("pulse retriggered");
    retrigger_restart_a: assert property (s_norm_exec and tt == TT_RTPULSE && raw_r && // R13
        cin_rise && setpt_r != '0 |=> raw_r && exp_r == '0)
        else $error("retrigger did not restart");
    oper_reset_a: assert property (run_en && op_rst_r && !reg_wr |=> !op_rst_r) // R14
        else $error("operator reset did not self-clear");
    auto_copy_a: assert property (run_en && op_mode == OPM_AUTO |=> // R20
        discrete_out_r == (raw_r ^ $past(inversion_mask[4])))
        else $error("output does not follow raw output");
    config_error_a: assert property (reg_rd && reg_addr == REG_STAT && // R18
        (quies_option > QUIES_LAST || time_units > UNITS_MAX) |=> reg_rdata[4])
        else $error("config error not flagged");
endmodule

// ==== inc/dlt_pkg.sv ====
// Shared constants for the discrete logic timer: register map, field layout,
// encodings and execution timing.
// Assumes a 100 MHz system clock and one execution per fixed period.
package dlt_pkg;
    // Clock and execution period; times are counted in executions.
    localparam int CLK_PERIOD_NS = 10;
    localparam int EXEC_PERIOD_NS = 1000000;
    localparam int EXEC_CYCLES = (EXEC_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // Register byte offsets.
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_SETPT = 8'h04;
    localparam logic [7:0] REG_OPER = 8'h08;
    localparam logic [7:0] REG_STAT = 8'h0C;
    localparam logic [7:0] REG_ELAPSED = 8'h10;
    localparam logic [7:0] REG_REMAIN = 8'h14;
    localparam logic [7:0] REG_NSTART = 8'h18;
    // Control register field positions.
    localparam int CTRL_TYPE_LSB = 0;
    localparam int CTRL_COMB_LSB = 8;
    localparam int CTRL_QUIES_LSB = 16;
    localparam int CTRL_OPMODE_LSB = 18;
    localparam int CTRL_UNITS_LSB = 20;
    localparam int CTRL_INV_LSB = 24;
    // Operator register bit positions.
    localparam int OPER_RESET_BIT = 0;
    localparam int OPER_MANVAL_BIT = 1;
    // Reset values: combine OR, out of service, clearing quiescence.
    localparam logic [31:0] CTRL_RST = 32'h0000_0100;
    localparam logic [31:0] SETPT_RST = 32'h0000_0000;
    localparam logic [3:0] UNITS_MAX = 4'h3;
    // Timer function codes.
    localparam logic [2:0] TT_MEASURE = 3'h0;
    localparam logic [2:0] TT_ACCUMULATE_MODE = 3'h1;
    localparam logic [2:0] TT_COMPARE = 3'h2;
    localparam logic [2:0] TT_DELAY = 3'h3;
    localparam logic [2:0] TT_EXTEND = 3'h4;
    localparam logic [2:0] TT_DEBOUNCE = 3'h5;
    localparam logic [2:0] TT_PULSE = 3'h6;
    localparam logic [2:0] TT_RTPULSE = 3'h7;
    // Combine function codes.
    localparam logic [7:0] CMB_AND = 8'h00;
    localparam logic [7:0] CMB_OR = 8'h01;
    localparam logic [7:0] CMB_ANY2 = 8'h02;
    localparam logic [7:0] CMB_ANY3 = 8'h03;
    localparam logic [7:0] CMB_EXACT1 = 8'h15;
    localparam logic [7:0] CMB_EXACT2 = 8'h16;
    localparam logic [7:0] CMB_EXACT3 = 8'h17;
    localparam logic [7:0] CMB_EVEN = 8'h28;
    localparam logic [7:0] CMB_ODD = 8'h29;
    // Quiescence options and operating modes.
    localparam logic [1:0] QUIES_CLEAR = 2'h0;
    localparam logic [1:0] QUIES_LAST = 2'h1;
    localparam logic [1:0] OPM_OOS = 2'h0;
    localparam logic [1:0] OPM_MAN = 2'h1;
    localparam logic [1:0] OPM_AUTO = 2'h2;
endpackage

// ==== tb/discrete_logic_timer_tb.sv ====
// Self-checking bench for the discrete logic timer with a four-cycle execution.
// Assumes the upstream model delays every requested level by one clock.
`timescale 1ns/1ns
module discrete_logic_timer_tb import dlt_pkg::*;;
    localparam int EC = 4;
    logic clk_sys, sys_rst, reg_wr, reg_rd, want_rst, rst_conn, discrete_out, timer_reset_in;
    logic [7:0] reg_addr;
    logic [31:0] reg_wdata, reg_rdata, rd_val, acc_a;
    logic [3:0] want_in, discrete_in;
    logic [7:0] codes [9] = '{CMB_AND, CMB_OR, CMB_ANY2, CMB_ANY3, CMB_EXACT1,
        CMB_EXACT2, CMB_EXACT3, CMB_EVEN, CMB_ODD};
    logic [8:0] e2 = 9'h0a6;
    logic [8:0] e3 = 9'h14e;
    logic [8:0] e4 = 9'h08f;
    int bad_count, comparisons;

    // Device under test and its upstream partner.
    dlt_timer #(.EXEC_CYC(EC)) uut (.clk_sys(clk_sys), .sys_rst(sys_rst),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .discrete_in(discrete_in), .timer_reset_in(timer_reset_in),
        .timer_reset_connected(rst_conn), .discrete_out(discrete_out));
    dlt_upstream up (.clk_sys(clk_sys), .sys_rst(sys_rst), .want_in(want_in),
        .want_rst(want_rst), .discrete_in(discrete_in), .timer_reset_in(timer_reset_in));

    // Free-running 100 MHz clock.
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    // Compares one value and reports a mismatch at once.
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk_out(input logic e);
        #1;
        check(32'(discrete_out), 32'(e));
    endtask

    // Register writes and reads, one strobe cycle each.
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1 rd_val = reg_rdata;
    endtask

    task automatic run(input int n);
        repeat (n * EC) @(posedge clk_sys);
    endtask

    task automatic drive(input logic [3:0] v, input int n);
        want_in <= v;
        run(n);
    endtask

    function automatic logic [31:0] cw(input logic [2:0] tt, input logic [7:0] cmb,
        input logic [1:0] q, input logic [4:0] inv);
        return 32'(tt) | (32'(cmb) << CTRL_COMB_LSB) | (32'(q) << CTRL_QUIES_LSB)
            | (32'(OPM_AUTO) << CTRL_OPMODE_LSB) | (32'(inv) << CTRL_INV_LSB);
    endfunction

    // Selects a mode, then reinitialises it with a reset edge and lets it settle.
    task automatic prep(input logic [2:0] tt, input logic [1:0] q, input int sp);
        wr(REG_SETPT, 32'(sp));
        wr(REG_CTRL, cw(tt, CMB_OR, q, 5'h00));
        want_in <= 4'h0;
        want_rst <= 1'b1;
        run(2);
        want_rst <= 1'b0;
        run(sp + 2);
    endtask

    // Every combine code against two, three and four true inputs, then inversion.
    task automatic s_combine();
        for (int i = 0; i < 9; i++) begin
            wr(REG_CTRL, cw(TT_MEASURE, codes[i], QUIES_CLEAR, 5'h00));
            drive(4'h3, 2);
            chk_out(e2[i]);
            drive(4'h7, 2);
            chk_out(e3[i]);
            drive(4'hf, 2);
            chk_out(e4[i]);
        end
        wr(REG_CTRL, cw(TT_MEASURE, CMB_OR, QUIES_CLEAR, 5'h01));
        drive(4'h0, 2);
        chk_out(1'b1);
        wr(REG_CTRL, cw(TT_MEASURE, CMB_OR, QUIES_CLEAR, 5'h11));
        run(2);
        chk_out(1'b0);
    endtask

    // Interval timing, edge count and both quiescence options.
    task automatic s_measure();
        prep(TT_MEASURE, QUIES_LAST, 0);
        repeat (2) begin
            drive(4'h1, 2);
            drive(4'h0, 1);
        end
        drive(4'h1, 3);
        drive(4'h0, 1);
        rd(REG_ELAPSED);
        check(rd_val, 32'h0000_0002);
        rd(REG_REMAIN);
        check(rd_val, 32'h0000_0000);
        rd(REG_NSTART);
        check(rd_val, 32'h0000_0003);
        want_rst <= 1'b1;
        run(2);
        want_rst <= 1'b0;
        rd(REG_NSTART);
        check(rd_val, 32'h0000_0000);
        rd(REG_ELAPSED);
        check(rd_val, 32'h0000_0000);
        wr(REG_CTRL, cw(TT_MEASURE, CMB_OR, QUIES_CLEAR, 5'h00));
        drive(4'h1, 3);
        drive(4'h0, 1);
        rd(REG_ELAPSED);
        check(rd_val, 32'h0000_0000);
    endtask

    // Two equal true intervals must add up in accumulate mode.
    task automatic s_accumulate_mode();
        prep(TT_ACCUMULATE_MODE, QUIES_CLEAR, 0);
        drive(4'h1, 3);
        drive(4'h0, 2);
        rd(REG_ELAPSED);
        acc_a = rd_val;
        check(32'(acc_a == 0), 32'h0000_0000);
        drive(4'h1, 3);
        drive(4'h0, 2);
        rd(REG_ELAPSED);
        check(rd_val, acc_a << 1);
        rd(REG_REMAIN);
        check(rd_val, 32'h0000_0000);
    endtask

    // Compare and delay: short pulse hidden, long one passed, fall immediate.
    task automatic s_delay(input logic [2:0] tt);
        prep(tt, QUIES_CLEAR, 5);
        drive(4'h1, 2);
        drive(4'h0, 4);
        chk_out(1'b0);
        drive(4'h1, 3);
        chk_out(1'b0);
        rd(REG_REMAIN);
        check(32'(rd_val inside {32'h0000_0002, 32'h0000_0003}), 32'h0000_0001);
        run(4);
        chk_out(1'b1);
        rd(REG_REMAIN);
        check(rd_val, 32'h0000_0000);
        drive(4'h0, 1);
        chk_out(1'b0);
    endtask

    // Extend holds through short gaps and passes a rise at once.
    task automatic s_extend();
        prep(TT_EXTEND, QUIES_CLEAR, 5);
        drive(4'h1, 2);
        chk_out(1'b1);
        drive(4'h0, 3);
        drive(4'h1, 1);
        drive(4'h0, 3);
        chk_out(1'b1);
        run(4);
        chk_out(1'b0);
        drive(4'h1, 1);
        chk_out(1'b1);
    endtask

    // Debounce filters short excursions in both directions.
    task automatic s_debounce();
        prep(TT_DEBOUNCE, QUIES_CLEAR, 4);
        drive(4'h1, 2);
        chk_out(1'b0);
        drive(4'h0, 3);
        drive(4'h1, 6);
        chk_out(1'b1);
        drive(4'h0, 2);
        drive(4'h1, 2);
        chk_out(1'b1);
        drive(4'h0, 6);
        chk_out(1'b0);
    endtask

    // A second rise mid-pulse is ignored by one-shot and restarts the other.
    task automatic s_pulse(input logic [2:0] tt, input logic late);
        prep(tt, QUIES_CLEAR, 4);
        drive(4'h1, 1);
        chk_out(1'b1);
        drive(4'h0, 2);
        drive(4'h1, 1);
        drive(4'h0, 2);
        chk_out(late);
        run(4);
        chk_out(1'b0);
    endtask

    // Operator reset with the pin unconnected, fault flags, unmapped read.
    task automatic s_oper();
        wr(REG_CTRL, cw(TT_MEASURE, CMB_OR, QUIES_CLEAR, 5'h00));
        rst_conn <= 1'b0;
        drive(4'h1, 1);
        drive(4'h0, 1);
        wr(REG_OPER, 32'h0000_0001);
        run(2);
        rd(REG_OPER);
        check(32'(rd_val[OPER_RESET_BIT]), 32'h0000_0000);
        rd(REG_NSTART);
        check(rd_val, 32'h0000_0000);
        @(posedge clk_sys);
        rst_conn <= 1'b1;
        wr(REG_CTRL, cw(TT_MEASURE, CMB_OR, 2'h2, 5'h00));
        rd(REG_STAT);
        check(32'(rd_val[4]), 32'h0000_0001);
        wr(REG_CTRL, cw(TT_MEASURE, CMB_OR, QUIES_CLEAR, 5'h00) | 32'h00f0_0000);
        rd(REG_STAT);
        check(32'(rd_val[4]), 32'h0000_0001);
        wr(REG_CTRL, cw(TT_MEASURE, CMB_OR, QUIES_CLEAR, 5'h00));
        rd(REG_STAT);
        check(32'(rd_val[5:4]), 32'h0000_0000);
        wr(REG_CTRL, cw(TT_MEASURE, CMB_OR, QUIES_CLEAR, 5'h00) & 32'hfff3_ffff);
        rd(REG_STAT);
        check(32'(rd_val[5]), 32'h0000_0001);
        rd(8'h40);
        check(rd_val, 32'h0000_0000);
    endtask

    // Prints the counts and the verdict, then stops the run.
    task automatic conclude();
        $display("comparisons=%0d bad_count=%0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // Watchdog well beyond the roughly one thousand cycles the sequence needs.
    initial begin
        #(20_000 * 10);
        bad_count++;
        conclude();
    end

    // Main sequence.
    initial begin
        sys_rst = 1'b1;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 32'h0000_0000;
        want_in = 4'h0;
        want_rst = 1'b0;
        rst_conn = 1'b1;
        bad_count = 0;
        comparisons = 0;
        repeat (12) @(posedge clk_sys);
        sys_rst <= 1'b0;
        s_combine();
        s_measure();
        s_accumulate_mode();
        s_delay(TT_COMPARE);
        s_delay(TT_DELAY);
        s_extend();
        s_debounce();
        s_pulse(TT_PULSE, 1'b0);
        s_pulse(TT_RTPULSE, 1'b1);
        s_oper();
        conclude();
    end
endmodule

// ==== tb/dlt_upstream.sv ====
// Upstream model that drives the four discrete inputs and the timer reset pin.
// Assumes the bench requests levels and this model launches them from a register.
`timescale 1ns/1ns
module dlt_upstream (
    // Clock and reset.
    input wire logic clk_sys,
    input wire logic sys_rst,
    // Levels requested by the bench.
    input wire logic [3:0] want_in,
    input wire logic want_rst,
    // Lines toward the timer.
    output logic [3:0] discrete_in,
    output logic timer_reset_in
);
    // Levels launch from a register, so each one changes only at a clock edge and holds for whole clock cycles.
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            discrete_in <= 4'h0;
            timer_reset_in <= 1'b0;
        end else begin
            discrete_in <= want_in;
            timer_reset_in <= want_rst;
        end
    end
endmodule
